// ===== hdl/asrc_host.sv
// Host controller driving a 16K x 4 asynchronous static RAM over its pins
`timescale 1ns/1ps
module asrc_host
  import asrc_pkg::*;
#(
  parameter int unsigned ADDR_W = ASRC_ADDR_W,
  parameter int unsigned DATA_W = ASRC_DATA_W
) (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  // User request
  input wire logic req_valid_i,
  input wire asrc_req_t req_i,
  output logic req_ready_o,
  output logic rd_valid_o,
  output logic [DATA_W-1:0] rd_data_o,
  // Memory pins
  output logic [ADDR_W-1:0] word_address_o,
  output asrc_strobe_t strobe_o,
  input wire logic [DATA_W-1:0] mem_dq_i,
  output logic [DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe_o
);

  typedef enum logic [2:0] {
    ASRC_IDLE, ASRC_READ, ASRC_WSETUP, ASRC_WPULSE, ASRC_WHOLD
  } asrc_state_t;

  asrc_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q, rdata_q;
  logic fast_q, rd_valid_q;
  asrc_strobe_t strobe_q;

  wire cnt_done = (cnt_q == ASRC_CNT_ZERO);
  wire take = req_valid_i && (state_q == ASRC_IDLE);
  // Fast write hold is padded so pulse and hold still cover the full cycle time
  wire [3:0] fw_pad = 4'(ASRC_FWC_CYC - ASRC_FWP_CYC);

  assign req_ready_o = (state_q == ASRC_IDLE);
  assign rd_valid_o = rd_valid_q;
  assign rd_data_o = rdata_q;
  assign word_address_o = addr_q;
  assign strobe_o = strobe_q;
  assign mem_dq_o = wdata_q;

  // Host drives data during the write strobe and the hold after it; memory released it by then
  assign mem_dq_oe_o = (state_q == ASRC_WPULSE) || (state_q == ASRC_WHOLD);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - 4'h1;
    case (state_q)
      ASRC_IDLE: begin
        if (req_valid_i) begin
          if (req_i.write) begin
            state_d = ASRC_WSETUP;
            cnt_d = ASRC_CNT_ZERO;
          end else begin
            state_d = ASRC_READ;
            cnt_d = 4'(ASRC_RD_CYC);
          end
        end
      end
      ASRC_READ: if (cnt_done) state_d = ASRC_IDLE;
      ASRC_WSETUP: begin
        state_d = ASRC_WPULSE;
        cnt_d = fast_q ? 4'(ASRC_FWP_CYC) : 4'(ASRC_WP_CYC);
      end
      ASRC_WPULSE: begin
        if (cnt_done) begin
          state_d = ASRC_WHOLD;
          cnt_d = fast_q ? fw_pad : 4'(ASRC_AH_CYC);
        end
      end
      ASRC_WHOLD: if (cnt_done) state_d = ASRC_IDLE;
      default: state_d = ASRC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q <= ASRC_IDLE;
      cnt_q <= ASRC_CNT_ZERO;
    end else if (clk_en_i) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Address and data latched only when a request is taken
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      addr_q <= '0;
      wdata_q <= '0;
      fast_q <= 1'b0;
    end else if (clk_en_i && take) begin
      addr_q <= req_i.addr[ADDR_W-1:0];
      wdata_q <= req_i.wdata[DATA_W-1:0];
      fast_q <= req_i.fast;
    end
  end

  // Strobes come from flops so the pins never glitch
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      strobe_q <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    end else if (clk_en_i) begin
      strobe_q.cs_n <= !(state_d != ASRC_IDLE);
      strobe_q.oe_n <= !(state_d == ASRC_READ);
      strobe_q.we_n <= !(state_d == ASRC_WPULSE);
    end
  end

  // Sample read data on the last read cycle, access time elapsed
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_q <= '0;
      rd_valid_q <= 1'b0;
    end else if (clk_en_i) begin
      rd_valid_q <= (state_q == ASRC_READ) && cnt_done;
      if ((state_q == ASRC_READ) && cnt_done) rdata_q <= mem_dq_i;
    end
  end

  // Assertions
  // One cycle is 10 ns of pin time, so a repetition of n cycles stands for
  // n times 10 ns; a low clock enable can only ever stretch the strobes.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  // Address and select discipline
  addr_stable_wr_a: assert property (
    !strobe_o.cs_n && !strobe_o.we_n |=> $stable(word_address_o))
    else $error("Address moved during write");

  addr_move_a: assert property (
    !$stable(word_address_o) |-> $past(strobe_o.we_n) && strobe_o.we_n)
    else $error("Address moved with write strobe low");

  deselect_a: assert property (
    state_q == ASRC_IDLE && $past(state_q) == ASRC_IDLE |-> strobe_o.cs_n)
    else $error("Chip selected when idle");

  // Write strobe timing
  // Select leads the write strobe by a cycle so the address is settled
  wr_start_a: assert property (
    $fell(strobe_o.we_n) |-> !strobe_o.cs_n && !$past(strobe_o.cs_n))
    else $error("Write started without prior select");

  pulse_width_a: assert property (
    clk_en_i && $fell(strobe_o.we_n) && !fast_q |->
      (!strobe_o.we_n && !strobe_o.cs_n) [*2])
    else $error("Write pulse too short");

  fast_len_a: assert property (
    clk_en_i && $fell(strobe_o.we_n) && fast_q |->
      (!strobe_o.we_n && !strobe_o.cs_n && strobe_o.oe_n) [*2])
    else $error("Fast write pulse too short");

  addr_hold_a: assert property (
    clk_en_i && $rose(strobe_o.we_n) && !fast_q |-> !strobe_o.cs_n &&
      $stable(word_address_o))
    else $error("Address hold violated");

  no_oe_write_a: assert property (
    !strobe_o.we_n |-> strobe_o.oe_n)
    else $error("Output enable low during write");

  // Data bus ownership
  no_drive_read_a: assert property (
    !strobe_o.oe_n |-> !mem_dq_oe_o && strobe_o.we_n)
    else $error("Bus contention during read");

  read_sel_a: assert property (
    !strobe_o.oe_n |-> !strobe_o.cs_n)
    else $error("Output enable low while deselected");

  data_setup_a: assert property (
    !strobe_o.we_n |-> mem_dq_oe_o && $stable(mem_dq_o))
    else $error("Write data not stable");

  // Data must still stand on the edge that ends the write
  data_hold_a: assert property (
    $rose(strobe_o.we_n) |-> mem_dq_oe_o && $stable(mem_dq_o))
    else $error("Write data released too early");

  read_len_a: assert property (
    clk_en_i && $fell(strobe_o.oe_n) ##0 clk_en_i [*4] |=> rd_valid_o)
    else $error("Read data sampled early");

  // Main scenarios
  rd_cov_c: cover property (rd_valid_o);
  wr_cov_c: cover property ($rose(strobe_o.we_n) && !fast_q);
  fw_cov_c: cover property ($rose(strobe_o.we_n) && fast_q);
  stall_cov_c: cover property (!clk_en_i && !strobe_o.oe_n);
  hold_cov_c: cover property ($rose(strobe_o.we_n) ##1 !strobe_o.cs_n);

endmodule // asrc_host

// ===== hdl/asrc_pkg.sv
// Package for the async SRAM host controller: timing constants and carriers
package asrc_pkg;

  localparam int unsigned ASRC_CLK_PERIOD_NS = 10;
  localparam int unsigned ASRC_ADDR_W = 14;
  localparam int unsigned ASRC_DATA_W = 4;

  // Fastest grade figures in ns
  localparam int unsigned ASRC_T_ACCESS_NS = 25;
  localparam int unsigned ASRC_T_OE_ACC_NS = 15;
  localparam int unsigned ASRC_T_WP_NS = 20;
  localparam int unsigned ASRC_T_DS_NS = 13;
  localparam int unsigned ASRC_T_AH_NS = 5;
  localparam int unsigned ASRC_T_WZ_NS = 15;
  localparam int unsigned ASRC_T_FWP_NS = 13;
  localparam int unsigned ASRC_T_FWC_NS = 18;

  // Least times round up to whole cycles
  localparam int unsigned ASRC_RD_CYC =
    (ASRC_T_ACCESS_NS + ASRC_CLK_PERIOD_NS - 1) / ASRC_CLK_PERIOD_NS;
  localparam int unsigned ASRC_WP_CYC =
    (ASRC_T_WP_NS + ASRC_CLK_PERIOD_NS - 1) / ASRC_CLK_PERIOD_NS;
  localparam int unsigned ASRC_WZ_CYC =
    (ASRC_T_WZ_NS + ASRC_CLK_PERIOD_NS - 1) / ASRC_CLK_PERIOD_NS;
  localparam int unsigned ASRC_AH_CYC =
    (ASRC_T_AH_NS + ASRC_CLK_PERIOD_NS - 1) / ASRC_CLK_PERIOD_NS;
  localparam int unsigned ASRC_FWP_CYC =
    (ASRC_T_FWP_NS + ASRC_CLK_PERIOD_NS - 1) / ASRC_CLK_PERIOD_NS;
  localparam int unsigned ASRC_FWC_CYC =
    (ASRC_T_FWC_NS + ASRC_CLK_PERIOD_NS - 1) / ASRC_CLK_PERIOD_NS;

  localparam logic [3:0] ASRC_CNT_ZERO = 4'h0;

  typedef struct packed {
    logic write;
    logic fast;
    logic [ASRC_ADDR_W-1:0] addr;
    logic [ASRC_DATA_W-1:0] wdata;
  } asrc_req_t;

  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
  } asrc_strobe_t;

endpackage

// ===== tb/asrc_sram_model.sv
// Behavioural 16K x 4 asynchronous static RAM seen by the host controller
`timescale 1ns/1ps
module asrc_sram_model
  import asrc_pkg::*;
(
  // Memory pins
  input wire logic [ASRC_ADDR_W-1:0] word_address_i,
  input wire asrc_strobe_t strobe_i,
  input wire logic [ASRC_DATA_W-1:0] dq_i,
  // Memory drive
  output logic [ASRC_DATA_W-1:0] dq_o,
  output logic dq_oe_o
);
  logic [ASRC_DATA_W-1:0] mem_q [2**ASRC_ADDR_W];
  logic [ASRC_DATA_W-1:0] last_q = 4'h0;
  wire [ASRC_DATA_W-1:0] word = mem_q[word_address_i];
  wire rd_en = !strobe_i.cs_n && !strobe_i.oe_n && strobe_i.we_n;
  wire rd_dly;
  // Data appears only after the access time; release is immediate
  assign #(ASRC_T_ACCESS_NS) rd_dly = rd_en;
  assign dq_oe_o = rd_en && rd_dly;
  // Undriven bus shows the inverse of the last word so stale data never passes
  assign dq_o = dq_oe_o ? word : ~last_q;
  always @* begin
    if (dq_oe_o) last_q = word;
  end
  always @(posedge strobe_i.we_n) begin
    if (!strobe_i.cs_n) mem_q[word_address_i] = dq_i;
  end
  always @(posedge strobe_i.cs_n) begin
    if (!strobe_i.we_n) mem_q[word_address_i] = dq_i;
  end
endmodule // asrc_sram_model

// ===== tb/asrc_host_tb_top.sv
// Self-checking bench for the async SRAM host controller
`timescale 1ns/1ps
module asrc_host_tb_top;
  import asrc_pkg::*;
  logic clk = 0, srst = 1, en = 1, vld = 0, rdy, rv, doe, moe;
  asrc_req_t req = '0;
  logic [3:0] rd, hdq, mdq;
  logic [13:0] adr, pa = 14'h0;
  asrc_strobe_t stb;
  wire [3:0] dq = doe ? hdq : mdq;
  int n_errors = 0, n_tests = 0, cyc = 0;
  initial forever #5 clk = ~clk;
  asrc_host i_dut (.ref_clk_i(clk), .srst_i(srst), .clk_en_i(en),
    .req_valid_i(vld), .req_i(req), .req_ready_o(rdy), .rd_valid_o(rv),
    .rd_data_o(rd), .word_address_o(adr), .strobe_o(stb), .mem_dq_i(dq),
    .mem_dq_o(hdq), .mem_dq_oe_o(doe));
  asrc_sram_model i_mem (.word_address_i(adr), .strobe_i(stb), .dq_i(dq),
    .dq_o(mdq), .dq_oe_o(moe));
  task automatic check(input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      complete_run();
    end
  end
  // During a write the bus is ours alone and the address must not move
  always @(posedge clk) begin
    if (!stb.cs_n) pa <= adr;
    if (!srst && !stb.we_n) begin
      check({stb.cs_n, stb.oe_n, doe, moe}, 4'b0110);
      check(adr, pa);
    end
  end
  task automatic issue(input logic w, f, input logic [13:0] a,
                       input logic [3:0] d);
    @(negedge clk);
    vld = 1;
    req = '{write: w, fast: f, addr: a, wdata: d};
    for (int i = 0; i < 20 && rdy !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    vld = 0;
  endtask
  task automatic rd_chk(input logic [13:0] a, input logic [3:0] e,
                        input int lat, input int stall);
    int k;
    issue(0, 0, a, 4'h0);
    for (k = 1; k < 20; k++) begin
      @(negedge clk);
      // Freeze only after the take, so the request itself is never lost
      if (k == 1 && stall > 0) en = 0;
      if (k == 1 + stall && stall > 0) en = 1;
      if (rv === 1'b1) break;
    end
    check(k, lat);
    check(rd, e);
  endtask
  task automatic t_norm;
    issue(1, 0, 14'h0000, 4'h5);
    issue(1, 0, 14'h3fff, 4'ha);
    issue(1, 0, 14'h1555, 4'hc);
    rd_chk(14'h3fff, 4'ha, 4, 0);
    rd_chk(14'h0000, 4'h5, 4, 0);
    rd_chk(14'h1555, 4'hc, 4, 0);
    $display("test normal writes done");
  endtask
  task automatic t_fast;
    for (int i = 0; i < 4; i++) issue(1, 1, 14'(256 + i), 4'(3 << i));
    for (int i = 0; i < 4; i++) rd_chk(14'(256 + i), 4'(3 << i), 4, 0);
    $display("test fast writes done");
  endtask
  task automatic t_stall;
    issue(1, 0, 14'h0000, 4'h9);
    // Frozen clock enable stretches the access by exactly the stall
    rd_chk(14'h0000, 4'h9, 7, 3);
    $display("test stalled read done");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    srst = 0;
    check({stb, doe, rdy, rv, adr}, {6'h3a, 14'h0});
    t_norm();
    t_fast();
    t_stall();
    complete_run();
  end
endmodule // asrc_host_tb_top
